// file: hdl/clkcfg_defines.vh
// register offsets, field positions and codes for the channel 6/7 divider configuration
`ifndef CLKCFG_DEFINES_VH
`define CLKCFG_DEFINES_VH

// register indices on the configuration port
`define REG_CH6_CONTROL 8'h0F
`define REG_CH6_WHOLE_FRAC_HI 8'h10
`define REG_CH6_FRAC_LO 8'h11
`define REG_CH7_CONTROL 8'h12
`define REG_CH7_WHOLE_FRAC_HI 8'h13
`define REG_CH7_FRAC_LO 8'h14

// reset values
`define CONTROL_RESET 16'h0000
`define WHOLE_FRAC_HI_RESET 16'h0000
`define FRAC_LO_RESET 16'h0000

// writable bits, reserved bits are not stored and read as zero
`define CONTROL_MASK 16'h1FDF
`define WHOLE_FRAC_HI_MASK 16'h0FFF
`define FRAC_LO_MASK 16'hFFFF

// control register fields
`define PRESCALE_HI 12
`define PRESCALE_LO 10
`define FRAC_ON_BIT 9
`define EDGE_RATE_BIT 8
`define NEG_SIDE_BIT 7
`define POS_SIDE_BIT 6
`define DRIVER_HI 4
`define DRIVER_LO 3
`define OUT_STATE_HI 2
`define OUT_STATE_LO 1
`define RAIL_BIT 0

// whole ratio / fraction high register fields
`define WHOLE_HI 11
`define WHOLE_LO 4
`define FRAC_TOP_HI 3
`define FRAC_TOP_LO 0

// prescale codes
`define PRESCALE_DIV2 3'h0
`define PRESCALE_DIV3 3'h1
`define PRESCALE_DIV1 3'h7

// output state codes
`define OUT_OFF 2'h0
`define OUT_CLOCK 2'h1
`define OUT_LOW 2'h2
`define OUT_HIGH 2'h3

// driver kind codes
`define DRV_LVDS_A 2'h0
`define DRV_LVDS_B 2'h1
`define DRV_CMOS 2'h2
`define DRV_HCSL 2'h3

`endif

// file: hdl/frac_channel_div.v
// one channel divider: optional prescaler, whole ratio plus twenty-bit fraction
`timescale 1ns/1ps
`include "clkcfg_defines.vh"

module frac_channel_div (
   // clock and reset
   input wire mclk,
   input wire reset,
   // settings
   input wire fraction_path_on,
   input wire [2:0] prescale_sel,
   input wire [7:0] whole_ratio,
   input wire [19:0] fraction_value,
   // divided clock
   output reg clk_level,
   output reg period_tick
);

   reg [1:0] pre_cnt_reg;
   reg [1:0] pre_cnt_next;
   reg [1:0] pre_limit;
   reg [8:0] cnt_reg;
   reg [8:0] cnt_next;
   reg [19:0] acc_reg;
   reg [19:0] acc_next;
   reg extra_reg;
   reg extra_next;
   reg [20:0] acc_sum;
   reg [8:0] period_m1;
   reg step;
   reg wrap;

   always @* begin
      // prescaler bypassed while the fraction path is off
      pre_limit = 2'h0;
      if (fraction_path_on) begin
         case (prescale_sel)
            `PRESCALE_DIV2: pre_limit = 2'h1;
            `PRESCALE_DIV3: pre_limit = 2'h2;
            `PRESCALE_DIV1: pre_limit = 2'h0;
            // reserved codes fall back to divide by one
            default: pre_limit = 2'h0;
         endcase
      end
      step = (pre_cnt_reg >= pre_limit);
      pre_cnt_next = step ? 2'h0 : pre_cnt_reg + 2'h1;
      period_m1 = {1'b0, whole_ratio} + {8'h00, extra_reg};
      wrap = step && (cnt_reg >= period_m1);
      acc_sum = {1'b0, acc_reg} + {1'b0, fraction_value};
      acc_next = acc_reg;
      extra_next = extra_reg;
      cnt_next = cnt_reg;
      if (wrap) begin
         cnt_next = 9'h000;
         if (fraction_path_on) begin
            // carry out of the accumulator stretches the next period by one
            acc_next = acc_sum[19:0];
            extra_next = acc_sum[20];
         end else begin
            acc_next = 20'h00000;
            extra_next = 1'b0;
         end
      end else if (step) begin
         cnt_next = cnt_reg + 9'h001;
      end
   end

   always @(posedge mclk) begin
      if (reset) begin
         pre_cnt_reg <= 2'h0;
         cnt_reg <= 9'h000;
         acc_reg <= 20'h00000;
         extra_reg <= 1'b0;
         clk_level <= 1'b0;
         period_tick <= 1'b0;
      end else begin
         pre_cnt_reg <= pre_cnt_next;
         cnt_reg <= cnt_next;
         acc_reg <= acc_next;
         extra_reg <= extra_next;
         period_tick <= wrap;
         // high for the first half of each period; a ratio of one stays high
         clk_level <= ({cnt_next, 1'b0} < ({1'b0, period_m1} + 10'h001));
      end
   end

endmodule // frac_channel_div

// file: hdl/clkcfg_top.v
// channel 6 and 7 divider configuration registers and output control
// Function
// - prescale code 000 divides by 2, 001 by 3, 111 by 1; others reserved.
// - channel 6 prescaler is bypassed while its fraction enable is clear.
// - control bit 9 turns the channel fraction divider on or off.
// - whole ratio sits in bits 11 to 4; divide ratio is value plus one.
// - fraction top four bits in bits 3 to 0, low sixteen in next register.
// - output state: 00 off, 01 clock, 10 static low, 11 static high.
// - driver bits 4 to 3: 00/01 low-swing differential, 10 CMOS, 11 host-clock.
// - negative CMOS side acts only while the positive side is enabled.
// - bit 8 clear gives normal edge rate, set gives slow edge rate.
// - bit 0 clear selects the 1.8 V rail, set the 2.5/3.3 V rail.
// - channel 7 uses the same control layout, prescaler bypassed when bit 9 clear.
// - channel 7 ratio and fraction sit in the two registers after its control.
`timescale 1ns/1ps
`include "clkcfg_defines.vh"

module clkcfg_top (
   // clock and reset
   input wire mclk,
   input wire reset,
   // configuration port, one 16-bit word per register index
   input wire [7:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [15:0] reg_rdata,
   output reg reg_rvalid,
   // channel pins, index 0 is channel 6, index 1 is channel 7
   output wire [1:0] ch_pos_out,
   output wire [1:0] ch_neg_out,
   output wire [1:0] ch_pos_oe,
   output wire [1:0] ch_neg_oe,
   // driver and rail settings per channel
   output wire [1:0] ch_diff_lowswing,
   output wire [1:0] ch_cmos,
   output wire [1:0] ch_hostclk,
   output wire [1:0] ch_slow_edge,
   output wire [1:0] ch_rail_high,
   // one-cycle pulse at every divided period end while the output state is clock
   output wire [1:0] ch_period_tick
);

   // register storage, indexed by channel
   reg [15:0] control_reg [0:1];
   reg [15:0] whole_frac_hi_reg [0:1];
   reg [15:0] frac_lo_reg [0:1];

   reg [15:0] rdata_next;
   reg hit;
   reg wr_sel;
   reg [1:0] wr_kind;
   reg [15:0] wr_mask;

   // address decode shared by write and read
   always @* begin
      hit = 1'b1;
      wr_sel = 1'b0;
      wr_kind = 2'h0;
      case (reg_addr)
         `REG_CH6_CONTROL: begin
            wr_sel = 1'b0;
            wr_kind = 2'h0;
         end
         `REG_CH6_WHOLE_FRAC_HI: begin
            wr_sel = 1'b0;
            wr_kind = 2'h1;
         end
         `REG_CH6_FRAC_LO: begin
            wr_sel = 1'b0;
            wr_kind = 2'h2;
         end
         `REG_CH7_CONTROL: begin
            wr_sel = 1'b1;
            wr_kind = 2'h0;
         end
         `REG_CH7_WHOLE_FRAC_HI: begin
            wr_sel = 1'b1;
            wr_kind = 2'h1;
         end
         `REG_CH7_FRAC_LO: begin
            wr_sel = 1'b1;
            wr_kind = 2'h2;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // reserved bits are dropped so a careless write cannot disturb the channel
   always @* begin
      case (wr_kind)
         2'h0: wr_mask = `CONTROL_MASK;
         2'h1: wr_mask = `WHOLE_FRAC_HI_MASK;
         2'h2: wr_mask = `FRAC_LO_MASK;
         default: wr_mask = 16'h0000;
      endcase
   end

   // read mux, unmapped indices read zero
   always @* begin
      rdata_next = 16'h0000;
      if (hit) begin
         case (wr_kind)
            2'h0: rdata_next = control_reg[wr_sel];
            2'h1: rdata_next = whole_frac_hi_reg[wr_sel];
            2'h2: rdata_next = frac_lo_reg[wr_sel];
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   always @(posedge mclk) begin
      if (reset) begin
         reg_rdata <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_read;
         if (reg_read) begin
            reg_rdata <= rdata_next;
         end
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : chan
         wire [15:0] ctl;
         wire [15:0] whf;
         wire [2:0] prescale_sel;
         wire fraction_path_on;
         wire edge_rate_sel;
         wire neg_side_on;
         wire pos_side_on;
         wire [1:0] driver_kind;
         wire [1:0] output_state;
         wire rail_sel;
         wire [7:0] whole_ratio;
         wire [19:0] fraction_value;
         wire div_level;
         wire div_tick;
         reg is_cmos;
         reg level_next;
         reg pos_oe_next;
         reg neg_oe_next;
         reg pos_out_reg;
         reg neg_out_reg;
         reg pos_oe_reg;
         reg neg_oe_reg;
         reg lowswing_reg;
         reg cmos_reg;
         reg hostclk_reg;
         reg slow_edge_reg;
         reg rail_high_reg;
         reg tick_reg;

         // register writes for this channel
         always @(posedge mclk) begin
            if (reset) begin
               // rail select resets low; safe with a higher rail present
               control_reg[ch] <= `CONTROL_RESET;
               whole_frac_hi_reg[ch] <= `WHOLE_FRAC_HI_RESET;
               frac_lo_reg[ch] <= `FRAC_LO_RESET;
            end else if (reg_write && hit && (wr_sel == ch)) begin
               case (wr_kind)
                  2'h0: control_reg[ch] <= reg_wdata & wr_mask;
                  2'h1: whole_frac_hi_reg[ch] <= reg_wdata & wr_mask;
                  2'h2: frac_lo_reg[ch] <= reg_wdata & wr_mask;
                  default: control_reg[ch] <= control_reg[ch];
               endcase
            end
         end

         assign ctl = control_reg[ch];
         assign whf = whole_frac_hi_reg[ch];
         assign prescale_sel = ctl[`PRESCALE_HI:`PRESCALE_LO];
         assign fraction_path_on = ctl[`FRAC_ON_BIT];
         assign edge_rate_sel = ctl[`EDGE_RATE_BIT];
         assign neg_side_on = ctl[`NEG_SIDE_BIT];
         assign pos_side_on = ctl[`POS_SIDE_BIT];
         assign driver_kind = ctl[`DRIVER_HI:`DRIVER_LO];
         assign output_state = ctl[`OUT_STATE_HI:`OUT_STATE_LO];
         assign rail_sel = ctl[`RAIL_BIT];
         assign whole_ratio = whf[`WHOLE_HI:`WHOLE_LO];
         assign fraction_value = {whf[`FRAC_TOP_HI:`FRAC_TOP_LO], frac_lo_reg[ch]};

         frac_channel_div u_div (
            .mclk(mclk),
            .reset(reset),
            .fraction_path_on(fraction_path_on),
            .prescale_sel(prescale_sel),
            .whole_ratio(whole_ratio),
            .fraction_value(fraction_value),
            .clk_level(div_level),
            .period_tick(div_tick)
         );

         always @* begin
            is_cmos = (driver_kind == `DRV_CMOS);
            case (output_state)
               `OUT_CLOCK: level_next = div_level;
               `OUT_LOW: level_next = 1'b0;
               `OUT_HIGH: level_next = 1'b1;
               default: level_next = 1'b0;
            endcase
            // differential drivers use both legs whenever the output is not off
            pos_oe_next = (output_state != `OUT_OFF) && (!is_cmos || pos_side_on);
            // a lone negative enable is ignored
            neg_oe_next = (output_state != `OUT_OFF) && (!is_cmos || (pos_side_on && neg_side_on));
         end

         always @(posedge mclk) begin
            if (reset) begin
               pos_out_reg <= 1'b0;
               neg_out_reg <= 1'b0;
               pos_oe_reg <= 1'b0;
               neg_oe_reg <= 1'b0;
               lowswing_reg <= 1'b0;
               cmos_reg <= 1'b0;
               hostclk_reg <= 1'b0;
               slow_edge_reg <= 1'b0;
               rail_high_reg <= 1'b0;
               tick_reg <= 1'b0;
            end else begin
               pos_out_reg <= pos_oe_next & level_next;
               neg_out_reg <= neg_oe_next & ~level_next;
               pos_oe_reg <= pos_oe_next;
               neg_oe_reg <= neg_oe_next;
               lowswing_reg <= (driver_kind == `DRV_LVDS_A) || (driver_kind == `DRV_LVDS_B);
               cmos_reg <= is_cmos;
               hostclk_reg <= (driver_kind == `DRV_HCSL);
               slow_edge_reg <= edge_rate_sel;
               rail_high_reg <= rail_sel;
               tick_reg <= div_tick && (output_state == `OUT_CLOCK);
            end
         end

         assign ch_pos_out[ch] = pos_out_reg;
         assign ch_neg_out[ch] = neg_out_reg;
         assign ch_pos_oe[ch] = pos_oe_reg;
         assign ch_neg_oe[ch] = neg_oe_reg;
         assign ch_diff_lowswing[ch] = lowswing_reg;
         assign ch_cmos[ch] = cmos_reg;
         assign ch_hostclk[ch] = hostclk_reg;
         assign ch_slow_edge[ch] = slow_edge_reg;
         assign ch_rail_high[ch] = rail_high_reg;
         assign ch_period_tick[ch] = tick_reg;
      end
   endgenerate

endmodule // clkcfg_top

// file: dv/clkcfg_props.sv
// port assertions for the channel 6/7 divider configuration block
`timescale 1ns/1ps
module clkcfg_props (
   // clock and reset
   input wire mclk,
   input wire reset,
   // configuration port
   input wire [7:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   input wire [15:0] reg_rdata,
   input wire reg_rvalid,
   // channel pins and settings
   input wire [1:0] ch_pos_out,
   input wire [1:0] ch_pos_oe,
   input wire [1:0] ch_neg_oe,
   input wire [1:0] ch_diff_lowswing,
   input wire [1:0] ch_cmos,
   input wire [1:0] ch_hostclk,
   input wire [1:0] ch_slow_edge,
   input wire [1:0] ch_rail_high
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // pins follow a control write two edges later
   wire wr6 = reg_write && reg_addr == 8'h0F;
   wire wr7 = reg_write && reg_addr == 8'h12;
   rvalid_one_cycle_a: assert property (1 |=> reg_rvalid == $past(reg_read)) else $error("rvalid not one after read");
   unmapped_reads_zero_a: assert property (reg_read && (reg_addr < 8'h0F || reg_addr > 8'h14) |=>
      reg_rdata == 16'h0000) else $error("unmapped read not zero");
   reserved_reads_zero_a: assert property (reg_read && (reg_addr == 8'h0F || reg_addr == 8'h12) |=>
      reg_rdata[15:13] == 3'h0 && !reg_rdata[5]) else $error("reserved control bit read set");
   driver_decode_a: assert property (wr6 ##2 1 |-> {ch_diff_lowswing[0], ch_cmos[0], ch_hostclk[0]} ==
      {!$past(reg_wdata[4], 2), $past(reg_wdata[4:3], 2) == 2'h2, $past(reg_wdata[4:3], 2) == 2'h3})
      else $error("driver kind decode wrong");
   edge_rail_a: assert property (wr6 ##2 1 |-> ch_slow_edge[0] == $past(reg_wdata[8], 2) &&
      ch_rail_high[0] == $past(reg_wdata[0], 2)) else $error("edge rate or rail wrong");
   static_level_a: assert property (wr7 && reg_wdata[2] ##2 1 |->
      ch_pos_out[1] == ($past(reg_wdata[1], 2) & ch_pos_oe[1])) else $error("static level wrong");
   output_off_a: assert property (wr7 && reg_wdata[2:1] == 2'h0 ##2 1 |->
      ch_pos_oe[1] == 1'b0 && ch_neg_oe[1] == 1'b0) else $error("off channel still enabled");
   neg_needs_pos_a: assert property (wr7 && reg_wdata[4:3] == 2'h2 && !reg_wdata[6] ##2 1 |->
      ch_neg_oe[1] == 1'b0) else $error("negative side enabled alone");
endmodule // clkcfg_props
bind clkcfg_top clkcfg_props u_props (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .ch_pos_out(ch_pos_out), .ch_pos_oe(ch_pos_oe), .ch_neg_oe(ch_neg_oe), .ch_diff_lowswing(ch_diff_lowswing),
   .ch_cmos(ch_cmos), .ch_hostclk(ch_hostclk), .ch_slow_edge(ch_slow_edge), .ch_rail_high(ch_rail_high));

// file: dv/tb_top.sv
// register and divider tests for the channel 6/7 configuration block
`timescale 1ns/1ps
module tb_top;
   logic mclk = 0, reset = 1, reg_write = 0, reg_read = 0, reg_rvalid;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
   logic [1:0] po, no, poe, noe, dls, cm, hc, se, rh, tk;
   int fail_count = 0, cmp_count = 0, cyc, k;
   logic [15:0] mask [0:5] = '{16'h1FDF, 16'h0FFF, 16'hFFFF, 16'h1FDF, 16'h0FFF, 16'hFFFF};
   // period cases: channel, control, ratio word, expected cycles over two periods
   int p_ch [0:6] = '{0, 0, 0, 0, 0, 1, 1};
   logic [15:0] p_ctl [0:6] = '{16'h0002, 16'h0202, 16'h0602, 16'h1E02, 16'h1E02, 16'h0402, 16'h0602};
   logic [15:0] p_hi [0:6] = '{16'h0040, 16'h0040, 16'h0040, 16'h0040, 16'h0048, 16'h0040, 16'h0040};
   int p_exp [0:6] = '{10, 20, 30, 10, 11, 10, 30};
   // ch7 cmos pin cases: control and {pos_oe, neg_oe, pos_out, neg_out}
   logic [15:0] s_ctl [0:3] = '{16'h0096, 16'h00D6, 16'h00D4, 16'h00D0};
   logic [15:0] s_exp [0:3] = '{16'h0000, 16'h000E, 16'h000D, 16'h0000};
   always #50 mclk = ~mclk;
   clkcfg_top u_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .ch_pos_out(po), .ch_neg_out(no), .ch_pos_oe(poe), .ch_neg_oe(noe), .ch_diff_lowswing(dls),
      .ch_cmos(cm), .ch_hostclk(hc), .ch_slow_edge(se), .ch_rail_high(rh), .ch_period_tick(tk));
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task chkn(input string n, input int e, input int g);
      cmp_count++;
      if (g != e) begin
         fail_count++;
         $display("unexpected %s expected %0d seen %0d", n, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge mclk);
      reg_write <= 1'b0;
   endtask
   // rvalid and data stand 1 ns after the taking edge
   task rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1 chk("rvalid", 16'h0001, {15'h0, reg_rvalid});
      v = reg_rdata;
   endtask
   // first tick may close a period begun under old settings, so counting starts on the second
   task measure(input int ch, output int c);
      int seen, i;
      c = 0;
      seen = 0;
      for (i = 0; i < 2000 && seen < 4; i++) begin
         @(posedge mclk);
         #1;
         if (tk[ch] === 1'b1) seen++;
         if (seen >= 2 && seen <= 3) c++;
      end
   endtask
   task settle;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #3000000;
      fail_count++;
      test_done;
   end
   initial begin
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      for (k = 0; k < 6; k++) begin
         rd(8'h0F + k, d);
         chk("reset value", 16'h0000, d);
      end
      // reserved bits are always written as zero
      for (k = 0; k < 6; k++) begin
         wr(8'h0F + k, mask[k]);
         rd(8'h0F + k, d);
         chk("readback", mask[k], d);
      end
      wr(8'h15, 16'hFFFF);
      rd(8'h15, d);
      chk("unmapped", 16'h0000, d);
      rd(8'h0E, d);
      chk("unmapped", 16'h0000, d);
      for (k = 0; k < 4; k++) begin
         wr(8'h0F, 16'h0002 | (k << 3) | (k[0] ? 16'h0101 : 16'h0000));
         settle;
         chk("driver", {11'h0, k < 2, k == 2, k == 3, k[0], k[0]}, {11'h0, dls[0], cm[0], hc[0], se[0], rh[0]});
         chk("ch6 legs", {13'h0, k != 2, k != 2, k != 2}, {13'h0, poe[0], noe[0], po[0] ^ no[0]});
      end
      for (k = 0; k < 4; k++) begin
         wr(8'h12, s_ctl[k]);
         settle;
         chk("ch7 pins", s_exp[k], {12'h0, poe[1], noe[1], po[1], no[1]});
      end
      for (k = 0; k < 7; k++) begin
         wr(p_ch[k] ? 8'h12 : 8'h0F, p_ctl[k]);
         wr(p_ch[k] ? 8'h13 : 8'h10, p_hi[k]);
         wr(p_ch[k] ? 8'h14 : 8'h11, 16'h0000);
         measure(p_ch[k], cyc);
         chkn("period", p_exp[k], cyc);
      end
      // second reset in mid-run clears the registers again
      @(posedge mclk);
      reset <= 1'b1;
      @(posedge mclk);
      reset <= 1'b0;
      rd(8'h12, d);
      chk("reset value", 16'h0000, d);
      chk("reset pins", 16'h0000, {poe, noe, po, no, cm, hc, se, rh});
      test_done;
   end
endmodule // tb_top
